// file: rtl/mdd_decode.sv
// data memory address decoder with the 256-byte internal ram
// assumes core presents one access per cycle, answer one cycle later for ram, two cycles later for sfr
`timescale 1ns/1ps
`default_nettype none
module mdd_decode (
	// system
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	// core request
	input  wire logic                         req_valid,
	input  wire mdd_pkg::mdd_op_type          req_op,
	input  wire logic                         req_write,
	input  wire logic [mdd_pkg::MDD_ADDR_W-1:0] req_addr,
	input  wire logic [mdd_pkg::MDD_DATA_W-1:0] req_wdata,
	input  wire logic [1:0]                   bank_sel,
	// sfr space
	input  wire logic [mdd_pkg::MDD_DATA_W-1:0] sfr_rdata,
	output logic                              sfr_sel,
	output logic                              sfr_write,
	output logic      [6:0]                   sfr_addr,
	output logic      [mdd_pkg::MDD_DATA_W-1:0] sfr_wdata,
	// answer to the core
	output logic                              rsp_valid,
	output logic      [mdd_pkg::MDD_DATA_W-1:0] rsp_rdata,
	output logic                              rsp_bit,
	output mdd_pkg::mdd_tgt_type              rsp_target,
	// program memory sector of a flash address
	input  wire logic [12:0]                  flash_addr,
	output logic      [mdd_pkg::MDD_SECTOR_W-1:0] flash_sector
);
	import mdd_pkg::*;

	logic [7:0]        ram_r [0:MDD_RAM_BYTES-1];
	logic [7:0]        eff_addr;
	logic [2:0]        eff_bit;
	mdd_tgt_type       tgt_nxt;
	logic [7:0]        cur_byte;
	logic [7:0]        merged;
	logic              bit_rd;
	logic              sfr_pend_r;
	logic              rsp_valid_r;
	logic [7:0]        rsp_rdata_r;
	logic              rsp_bit_r;
	mdd_tgt_type       rsp_target_r;
	logic              sfr_sel_r;
	logic              sfr_write_r;
	logic [6:0]        sfr_addr_r;
	logic [7:0]        sfr_wdata_r;
	logic [3:0]        flash_sector_r;
	logic [2:0]        sfr_bit_r;
	logic              sfr_hit;

	// upper-half test, used by several decodes
	function automatic logic is_upper(input logic [7:0] a);
		return a >= MDD_SFR_BASE;
	endfunction

	// effective byte address and bit index per access kind
	always_comb begin
		eff_addr = req_addr;
		eff_bit  = 3'h0;
		unique case (req_op)
			MDD_OP_REGISTER: begin
				eff_addr = (8'(bank_sel) * MDD_BANK_SIZE) + {5'h00, req_addr[2:0]};
			end
			MDD_OP_BIT: begin
				if (is_upper(req_addr)) begin
					eff_addr = {req_addr[7:3], 3'h0};
				end else begin
					eff_addr = MDD_BIT_BASE + {4'h0, req_addr[6:3]};
				end
				eff_bit = req_addr[2:0];
			end
			default: begin
				eff_addr = req_addr;
			end
		endcase
	end

	// target selection
	always_comb begin
		tgt_nxt = MDD_TGT_LOW_RAM;
		if (is_upper(eff_addr)) begin
			if (req_op == MDD_OP_INDIRECT) begin
				tgt_nxt = MDD_TGT_UP_RAM;
			end else begin
				tgt_nxt = MDD_TGT_SFR;
			end
		end
	end

	// sfr bound access this cycle
	assign sfr_hit = req_valid && (tgt_nxt == MDD_TGT_SFR);

	// asynchronous read, a read in the write cycle sees the old byte
	assign cur_byte = ram_r[eff_addr];

	mdd_bit_merge u_merge (
		.byte_in  (cur_byte),
		.bit_pos  (eff_bit),
		.bit_val  (req_wdata[0]),
		.byte_out (merged),
		.bit_out  (bit_rd)
	);

	// ram writes, bit writes touch one bit only
	always_ff @(posedge clk_sys) begin
		if (req_valid && req_write && tgt_nxt != MDD_TGT_SFR) begin
			if (req_op == MDD_OP_BIT) begin
				ram_r[eff_addr] <= merged;
			end else begin
				ram_r[eff_addr] <= req_wdata;
			end
		end
	end

	// sfr strobes, one cycle per access
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sfr_sel_r   <= 1'b0;
			sfr_write_r <= 1'b0;
		end else begin
			sfr_sel_r   <= sfr_hit;
			sfr_write_r <= sfr_hit && req_write;
		end
	end

	// sfr address and write data, qualified by the strobes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sfr_addr_r  <= 7'h00;
			sfr_wdata_r <= MDD_RDATA_RST;
		end else begin
			sfr_addr_r  <= eff_addr[6:0];
			sfr_wdata_r <= req_wdata;
		end
	end

	// bit index kept for the sfr answer, the byte address has it cleared
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sfr_bit_r <= 3'h0;
		end else begin
			sfr_bit_r <= eff_bit;
		end
	end

	// sfr answer due one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sfr_pend_r <= 1'b0;
		end else begin
			sfr_pend_r <= sfr_hit;
		end
	end

	// answer strobe: ram next cycle, sfr once its data is back
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_valid_r <= 1'b0;
		end else begin
			rsp_valid_r <= (req_valid && !sfr_hit) || sfr_pend_r;
		end
	end

	// answer target, held until the next request
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_target_r <= MDD_TGT_LOW_RAM;
		end else if (req_valid) begin
			rsp_target_r <= tgt_nxt;
		end
	end

	// answer byte, sfr data wins over a ram read in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_rdata_r <= MDD_RDATA_RST;
		end else if (sfr_pend_r) begin
			rsp_rdata_r <= sfr_rdata;
		end else if (req_valid) begin
			rsp_rdata_r <= sfr_hit ? MDD_RDATA_RST : cur_byte;
		end
	end

	// answer bit
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_bit_r <= 1'b0;
		end else if (sfr_pend_r) begin
			rsp_bit_r <= sfr_rdata[sfr_bit_r];
		end else if (req_valid) begin
			rsp_bit_r <= sfr_hit ? 1'b0 : bit_rd;
		end
	end

	// flash sector index
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flash_sector_r <= 4'h0;
		end else begin
			flash_sector_r <= flash_addr[12:9];
		end
	end

	assign sfr_sel      = sfr_sel_r;
	assign sfr_write    = sfr_write_r;
	assign sfr_addr     = sfr_addr_r;
	assign sfr_wdata    = sfr_wdata_r;
	assign rsp_valid    = rsp_valid_r;
	assign rsp_rdata    = rsp_rdata_r;
	assign rsp_bit      = rsp_bit_r;
	assign rsp_target   = rsp_target_r;
	assign flash_sector = flash_sector_r;
endmodule
`default_nettype wire

// file: rtl/mdd_pkg.sv
// package for the data memory address decoder
// assumes a single system clock and synchronous active-low reset
package mdd_pkg;
	localparam int          MDD_ADDR_W      = 8;
	localparam int          MDD_DATA_W      = 8;
	localparam int          MDD_RAM_BYTES   = 256;
	localparam int          MDD_UPPER_BASE  = 128;
	localparam logic [7:0]  MDD_BANK_SIZE   = 8'h08;
	localparam logic [7:0]  MDD_BIT_BASE    = 8'h20;
	localparam logic [7:0]  MDD_BIT_BYTES   = 8'h10;
	localparam logic [7:0]  MDD_SFR_BASE    = 8'h80;
	localparam int          MDD_FLASH_BYTES = 8192;
	localparam int          MDD_SECTOR_BYTES = 512;
	localparam int          MDD_SECTOR_W    = 4;
	localparam logic [7:0]  MDD_RDATA_RST   = 8'h00;
	localparam logic [1:0]  MDD_BANK_RST    = 2'h0;

	// access kinds from the core
	typedef enum logic [3:0] {
		MDD_OP_DIRECT   = 4'h1,
		MDD_OP_INDIRECT = 4'h2,
		MDD_OP_REGISTER = 4'h4,
		MDD_OP_BIT      = 4'h8
	} mdd_op_type;

	// destination of a decoded access
	typedef enum logic [2:0] {
		MDD_TGT_LOW_RAM = 3'h1,
		MDD_TGT_UP_RAM  = 3'h2,
		MDD_TGT_SFR     = 3'h4
	} mdd_tgt_type;
endpackage

// file: rtl/mdd_bit_merge.sv
// bit read-modify-write helper for the bit-addressable bytes of the internal ram
// assumes bit index already reduced to a position within one byte
`timescale 1ns/1ps
`default_nettype none
module mdd_bit_merge (
	// byte in
	input  wire logic [7:0] byte_in,
	// bit select and value
	input  wire logic [2:0] bit_pos,
	input  wire logic       bit_val,
	// results
	output logic      [7:0] byte_out,
	output logic            bit_out
);
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_bit
			assign byte_out[g] = (bit_pos == 3'(g)) ? bit_val : byte_in[g];
		end
	endgenerate
	assign bit_out = byte_in[bit_pos];
endmodule
`default_nettype wire

// file: tb/mdd_sfr_model.sv
// sfr space model on the far side of the decoder
// assumes each sfr_sel pulse marks one access
`timescale 1ns/1ps
`default_nettype none
module mdd_sfr_model (
	// sfr side
	input  wire logic       clk_sys,
	input  wire logic       sfr_sel,
	input  wire logic       sfr_write,
	input  wire logic [6:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata
);
	logic [7:0] mem_r [128];
	// unselected reads give the inverse, never a stale byte
	assign sfr_rdata = sfr_sel ? mem_r[sfr_addr] : ~mem_r[sfr_addr];
	always_ff @(posedge clk_sys) begin
		if (sfr_sel && sfr_write)
			mem_r[sfr_addr] <= sfr_wdata;
	end
endmodule
`default_nettype wire

// file: tb/mdd_decode_props.sv
// checker on the decoder ports
// assumes bind onto mdd_decode
`timescale 1ns/1ps
`default_nettype none
module mdd_decode_props (
	// watched ports
	input wire logic                 clk_sys,
	input wire logic                 rst_n,
	input wire logic                 req_valid,
	input wire mdd_pkg::mdd_op_type  req_op,
	input wire logic [7:0]           req_addr,
	input wire logic                 req_write,
	input wire logic [7:0]           req_wdata,
	input wire logic [7:0]           sfr_rdata,
	input wire logic                 sfr_sel,
	input wire logic                 sfr_write,
	input wire logic [6:0]           sfr_addr,
	input wire logic [7:0]           sfr_wdata,
	input wire logic                 rsp_valid,
	input wire logic [7:0]           rsp_rdata,
	input wire mdd_pkg::mdd_tgt_type rsp_target,
	input wire logic [12:0]          flash_addr,
	input wire logic [3:0]           flash_sector
);
	import mdd_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_ind_up_ram: assert property (
		req_valid && req_op == MDD_OP_INDIRECT && req_addr[7] |=>
		rsp_valid && rsp_target == MDD_TGT_UP_RAM && !sfr_sel) else $error("indirect upper");
	a_dir_sfr: assert property (
		req_valid && req_op == MDD_OP_DIRECT && req_addr[7] |=>
		sfr_sel && sfr_addr == $past(req_addr[6:0])) else $error("direct upper");
	a_sfr_wr_data: assert property (
		req_valid && req_write && req_op == MDD_OP_DIRECT && req_addr[7] |=>
		sfr_write && sfr_wdata == $past(req_wdata)) else $error("sfr write");
	a_low_ram: assert property (
		req_valid && !req_addr[7] && (req_op == MDD_OP_DIRECT || req_op == MDD_OP_INDIRECT)
		|=> rsp_valid && rsp_target == MDD_TGT_LOW_RAM) else $error("lower half");
	a_reg_bank: assert property (
		req_valid && req_op == MDD_OP_REGISTER |=>
		rsp_valid && rsp_target == MDD_TGT_LOW_RAM && !sfr_sel) else $error("register op");
	a_bit_low: assert property (
		req_valid && req_op == MDD_OP_BIT && !req_addr[7] |=>
		rsp_valid && rsp_target == MDD_TGT_LOW_RAM) else $error("bit op");
	a_sfr_data: assert property (
		sfr_sel && !sfr_write |=> rsp_valid && rsp_target == MDD_TGT_SFR
		&& rsp_rdata == $past(sfr_rdata)) else $error("sfr answer");
	a_rsp_cause: assert property (
		rsp_valid |-> $past(req_valid) || $past(sfr_sel)) else $error("stray answer");
	a_flash_sec: assert property (
		1'b1 |=> flash_sector == $past(flash_addr[12:9])) else $error("flash sector");
	c_sfr: cover property (sfr_sel && !sfr_write);
	c_up: cover property (rsp_valid && rsp_target == MDD_TGT_UP_RAM);
	c_bit: cover property (req_valid && req_op == MDD_OP_BIT);
endmodule
`default_nettype wire

// file: tb/mdd_decode_test.sv
// self-checking bench for the data memory decoder
// assumes package, design, sfr model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module mdd_decode_test;
	import mdd_pkg::*;
	logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
	logic sfr_sel, sfr_write, rsp_valid, rsp_bit;
	logic [7:0] req_addr = 8'h00, req_wdata = 8'h00, sfr_rdata, sfr_wdata, rsp_rdata;
	logic [1:0] bank_sel = 2'h0;
	logic [6:0] sfr_addr;
	logic [12:0] flash_addr = 13'h0000;
	logic [3:0] flash_sector;
	mdd_op_type req_op = MDD_OP_DIRECT;
	mdd_tgt_type rsp_target;
	int fail_count = 0, n_checks = 0, cyc = 0;
	mdd_decode mdd_decode_inst (.clk_sys, .rst_n, .req_valid, .req_op, .req_write, .req_addr,
		.req_wdata, .bank_sel, .sfr_rdata, .sfr_sel, .sfr_write, .sfr_addr, .sfr_wdata,
		.rsp_valid, .rsp_rdata, .rsp_bit, .rsp_target, .flash_addr, .flash_sector);
	mdd_sfr_model mdd_sfr_model_inst (.clk_sys, .sfr_sel, .sfr_write, .sfr_addr, .sfr_wdata,
		.sfr_rdata);
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 1000) begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one access, then wait out its fixed answer latency
	task automatic acc(input mdd_op_type op, input logic w, input logic [7:0] a, d,
		input mdd_tgt_type t);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= op;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		repeat ((t == MDD_TGT_SFR) ? 1 : 0) @(posedge clk_sys);
		#1;
		chk("valid", 8'h01, {7'h00, rsp_valid});
		chk("target", 8'(t), 8'(rsp_target));
	endtask
	task automatic t_lower();
		acc(MDD_OP_DIRECT, 1'b1, 8'h7F, 8'h55, MDD_TGT_LOW_RAM);
		acc(MDD_OP_INDIRECT, 1'b0, 8'h7F, 8'h00, MDD_TGT_LOW_RAM);
		chk("lower", 8'h55, rsp_rdata);
	endtask
	task automatic t_upper();
		acc(MDD_OP_INDIRECT, 1'b1, 8'h90, 8'h3C, MDD_TGT_UP_RAM);
		acc(MDD_OP_DIRECT, 1'b1, 8'h90, 8'hC3, MDD_TGT_SFR);
		acc(MDD_OP_INDIRECT, 1'b0, 8'h90, 8'h00, MDD_TGT_UP_RAM);
		chk("upper", 8'h3C, rsp_rdata);
		acc(MDD_OP_DIRECT, 1'b0, 8'h90, 8'h00, MDD_TGT_SFR);
		chk("sfr", 8'hC3, rsp_rdata);
		acc(MDD_OP_BIT, 1'b0, 8'h92, 8'h00, MDD_TGT_SFR);
		chk("sfrbit", 8'h00, {7'h00, rsp_bit});
	endtask
	task automatic t_bank();
		for (int b = 0; b < 4; b++) begin
			@(posedge clk_sys);
			bank_sel <= 2'(b);
			acc(MDD_OP_REGISTER, 1'b1, 8'h03, 8'(8'h10 + b), MDD_TGT_LOW_RAM);
		end
		for (int b = 0; b < 4; b++) begin
			acc(MDD_OP_INDIRECT, 1'b0, 8'(b * 8 + 3), 8'h00, MDD_TGT_LOW_RAM);
			chk("bank", 8'(8'h10 + b), rsp_rdata);
		end
	endtask
	task automatic t_bit();
		acc(MDD_OP_DIRECT, 1'b1, 8'h21, 8'hC3, MDD_TGT_LOW_RAM);
		acc(MDD_OP_BIT, 1'b1, 8'h0D, 8'h01, MDD_TGT_LOW_RAM);
		acc(MDD_OP_DIRECT, 1'b0, 8'h21, 8'h00, MDD_TGT_LOW_RAM);
		chk("bitbyte", 8'hE3, rsp_rdata);
		acc(MDD_OP_BIT, 1'b0, 8'h0D, 8'h00, MDD_TGT_LOW_RAM);
		chk("bit", 8'h01, {7'h00, rsp_bit});
	endtask
	task automatic t_flash();
		@(posedge clk_sys);
		flash_addr <= 13'h1E00;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("sector", 8'h0F, {4'h0, flash_sector});
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_lower();
		t_upper();
		t_bank();
		t_bit();
		t_flash();
		print_verdict();
	end
endmodule
bind mdd_decode mdd_decode_props mdd_decode_props_inst (.clk_sys, .rst_n, .req_valid, .req_op,
	.req_addr, .req_write, .req_wdata, .sfr_rdata, .sfr_sel, .sfr_write, .sfr_addr,
	.sfr_wdata, .rsp_valid, .rsp_rdata, .rsp_target, .flash_addr, .flash_sector);
`default_nettype wire
